// [inc/hfe_pkg.sv]
// Constants and carriers for the framer event, status and mask block.
// Assumes one 100 MHz clock and a byte-wide register port.
//
// How it works
// - mask bit set enables, clear blocks; reset clear
// - tx store overflow, underflow, slip events
// - rx store overflow, underflow, slip events
// - message-done event per controller, read clears
// - packet-end on good, crc, overrun, abort end
// - packet-start event on opening byte, read clears
// - rx level above high watermark condition
// - rx fifo holds at least one byte
// - tx level below low watermark condition
// - tx fifo has room for a byte
// - fifo conditions interrupt on rising edge only
// - two controller status/mask pairs at 20h-23h
// - live tx empty, tx full, rx empty
// - live packet state from last fifo read
// - full rx fifo stops packet, reports overrun
// - tx drained before end: abort, latch underrun
// - live first-byte flag per controller
// - code-clear after 30 link bits without abort
// - link abort after eight ones in row
// - match event on either match value
// - code detector change event, then buffer read
`default_nettype none

package hfe_pkg;

   // ****************************************
   // register offsets
   // ****************************************
   localparam logic [7:0] ADDR_ES_STAT   = 8'h1E;
   localparam logic [7:0] ADDR_ES_MASK   = 8'h1F;
   localparam logic [7:0] ADDR_H1_STAT   = 8'h20;
   localparam logic [7:0] ADDR_H1_MASK   = 8'h21;
   localparam logic [7:0] ADDR_H2_STAT   = 8'h22;
   localparam logic [7:0] ADDR_H2_MASK   = 8'h23;
   localparam logic [7:0] ADDR_DL_STAT   = 8'h24;
   localparam logic [7:0] ADDR_DL_MASK   = 8'h25;
   localparam logic [7:0] ADDR_UO_INFO   = 8'h2D;
   localparam logic [7:0] ADDR_H1_INFO   = 8'h2E;
   localparam logic [7:0] ADDR_H2_INFO   = 8'h2F;
   localparam logic [7:0] ADDR_MATCH_ONE = 8'h30;
   localparam logic [7:0] ADDR_MATCH_TWO = 8'h31;
   localparam logic [7:0] ADDR_MF_MASK   = 8'h32;

   // ****************************************
   // implemented bits and reset values
   // ****************************************
   localparam logic [7:0] ES_BITS   = 8'h3F;
   localparam logic [7:0] HDLC_BITS = 8'h7F;
   localparam logic [7:0] DL_BITS   = 8'h3F;
   localparam logic [7:0] REG_RESET = 8'h00;

   // ****************************************
   // counts and codes
   // ****************************************
   localparam logic [7:0] FIFO_DEPTH  = 8'h80;
   localparam logic [3:0] ABORT_ONES  = 4'h8;
   localparam logic [4:0] CLEAR_BITS  = 5'h1E;
   localparam logic [2:0] PS_PROGRESS = 3'h0;
   localparam logic [2:0] PS_GOOD     = 3'h1;
   localparam logic [2:0] PS_CRC_ERR  = 3'h2;
   localparam logic [2:0] PS_ABORT    = 3'h3;
   localparam logic [2:0] PS_OVERRUN  = 3'h4;

   // ****************************************
   // carriers
   // ****************************************
   typedef struct packed {
      logic       tx_message_done;
      logic       rx_packet_end;
      logic       rx_packet_start;
      logic [7:0] rx_level;
      logic [7:0] tx_level;
      logic [7:0] rx_high_watermark_value;
      logic [7:0] tx_low_watermark_value;
      logic       rx_fifo_read;
      logic [2:0] rx_read_state;
      logic       rx_byte_write;
      logic       rx_first_byte;
      logic       tx_msg_end;
   } hfe_hdlc_t;

   typedef struct packed {
      logic tx_overflow;
      logic tx_underflow;
      logic rx_overflow;
      logic rx_underflow;
   } hfe_store_t;

   typedef struct packed {
      logic       bit_valid;
      logic       bit_value;
      logic       rx_buffer_full;
      logic       tx_buffer_drained;
      logic       byte_valid;
      logic [7:0] byte_value;
      logic       code_change;
   } hfe_link_t;

endpackage

`default_nettype wire

// [src/hfe_events.sv]
// Latched events, live conditions, masks and interrupt request for the
// elastic stores, two packet controllers and the facility data link.
// Assumes event inputs are one-cycle pulses synchronous to clk_i.
`default_nettype none

module hfe_events (
   input  wire logic                  clk_i,     // 100 MHz clock
   input  wire logic                  rstn_i,    // async reset, low
   input  wire logic [7:0]            addr_i,    // register address
   input  wire logic [7:0]            wdata_i,   // write data
   input  wire logic                  wr_i,      // write strobe
   input  wire logic                  rd_i,      // read strobe
   input  wire hfe_pkg::hfe_store_t   store_i,   // elastic store events
   input  wire hfe_pkg::hfe_hdlc_t [1:0] hdlc_i, // packet controllers
   input  wire hfe_pkg::hfe_link_t    link_i,    // data link events
   output logic [7:0]                 rdata_o,   // read data, next cycle
   output logic                       irq_o,     // interrupt request
   output logic [1:0]                 rx_halt_o, // stop rx packet pulse
   output logic [1:0]                 tx_abort_o // send abort pulse
);

   // ****************************************
   // functions
   // ****************************************
   // {above high, not empty, below low, not full}
   function automatic logic [3:0] fifo_cond(input hfe_pkg::hfe_hdlc_t h);
      fifo_cond = {h.rx_level > h.rx_high_watermark_value,
                   h.rx_level != 8'h00,
                   h.tx_level < h.tx_low_watermark_value,
                   h.tx_level < hfe_pkg::FIFO_DEPTH};
   endfunction

   function automatic logic rd_hit(input logic [7:0] a,
                                   input logic [7:0] ra,
                                   input logic       rd);
      rd_hit = rd && (a == ra);
   endfunction

   // ****************************************
   // state
   // ****************************************
   logic [5:0]       es_stat;
   logic [5:0]       next_es_stat;
   logic [5:0]       es_mask;
   logic [5:0]       next_es_mask;
   logic [1:0][2:0]  hd_evt;
   logic [1:0][2:0]  next_hd_evt;
   logic [1:0][3:0]  cond_prev;
   logic [1:0][3:0]  next_cond_prev;
   logic [1:0][3:0]  cond_edge;
   logic [1:0][3:0]  next_cond_edge;
   logic [1:0][6:0]  hd_mask;
   logic [1:0][6:0]  next_hd_mask;
   logic [1:0]       underrun;
   logic [1:0]       next_underrun;
   logic [1:0]       tx_open;
   logic [1:0]       next_tx_open;
   logic [1:0]       in_pkt;
   logic [1:0]       next_in_pkt;
   logic [1:0]       ovr_pend;
   logic [1:0]       next_ovr_pend;
   logic [1:0][2:0]  pkt_state;
   logic [1:0][2:0]  next_pkt_state;
   logic [5:0]       dl_stat;
   logic [5:0]       next_dl_stat;
   logic [5:0]       dl_mask;
   logic [5:0]       next_dl_mask;
   logic [3:0]       ones_cnt;
   logic [3:0]       next_ones_cnt;
   logic [4:0]       clr_cnt;
   logic [4:0]       next_clr_cnt;
   logic [7:0]       match_one;
   logic [7:0]       next_match_one;
   logic [7:0]       match_two;
   logic [7:0]       next_match_two;
   logic [7:0]       mf_mask;
   logic [7:0]       next_mf_mask;
   logic [7:0]       next_rdata;
   logic             next_irq;
   logic [1:0]       next_rx_halt;
   logic [1:0]       next_tx_abort;
   logic [1:0][3:0]  cond;
   logic [1:0]       stat_rd;
   logic [1:0]       underrun_hit;
   logic [1:0]       halt_hit;

   // ****************************************
   // event and condition logic
   // ****************************************
   always_comb
   begin
      next_es_stat   = es_stat;
      next_hd_evt    = hd_evt;
      next_cond_edge = cond_edge;
      next_underrun  = underrun;
      next_tx_open   = tx_open;
      next_in_pkt    = in_pkt;
      next_ovr_pend  = ovr_pend;
      next_pkt_state = pkt_state;
      next_dl_stat   = dl_stat;
      next_ones_cnt  = ones_cnt;
      next_clr_cnt   = clr_cnt;
      next_rx_halt   = 2'b00;
      next_tx_abort  = 2'b00;
      stat_rd[0]     = rd_hit(addr_i, hfe_pkg::ADDR_H1_STAT, rd_i);
      stat_rd[1]     = rd_hit(addr_i, hfe_pkg::ADDR_H2_STAT, rd_i);

      // clear on read first, so a same-cycle set wins
      if (rd_hit(addr_i, hfe_pkg::ADDR_ES_STAT, rd_i))
         next_es_stat = 6'h00;
      if (rd_hit(addr_i, hfe_pkg::ADDR_DL_STAT, rd_i))
         next_dl_stat = 6'h00;
      if (rd_hit(addr_i, hfe_pkg::ADDR_UO_INFO, rd_i))
         next_underrun = 2'b00;

      if (store_i.tx_overflow)
         next_es_stat[5] = 1'b1;
      if (store_i.tx_underflow)
         next_es_stat[4] = 1'b1;
      if (store_i.tx_overflow || store_i.tx_underflow)
         next_es_stat[3] = 1'b1;
      if (store_i.rx_overflow)
         next_es_stat[2] = 1'b1;
      if (store_i.rx_underflow)
         next_es_stat[1] = 1'b1;
      if (store_i.rx_overflow || store_i.rx_underflow)
         next_es_stat[0] = 1'b1;

      for (int c = 0; c < 2; c++)
      begin
         cond[c]         = fifo_cond(hdlc_i[c]);
         next_cond_prev[c] = cond[c];
         halt_hit[c]     = in_pkt[c] && hdlc_i[c].rx_byte_write &&
                           (hdlc_i[c].rx_level == hfe_pkg::FIFO_DEPTH);
         underrun_hit[c] = tx_open[c] && !hdlc_i[c].tx_msg_end &&
                           (hdlc_i[c].tx_level == 8'h00);
         if (stat_rd[c])
         begin
            next_hd_evt[c]    = 3'h0;
            next_cond_edge[c] = 4'h0;
         end
         next_cond_edge[c] = next_cond_edge[c] |
                             (cond[c] & ~cond_prev[c]);
         if (hdlc_i[c].tx_message_done)
            next_hd_evt[c][2] = 1'b1;
         if (hdlc_i[c].rx_packet_end || halt_hit[c])
            next_hd_evt[c][1] = 1'b1;
         if (hdlc_i[c].rx_packet_start)
            next_hd_evt[c][0] = 1'b1;

         if (hdlc_i[c].rx_packet_start)
            next_in_pkt[c] = 1'b1;
         if (hdlc_i[c].rx_packet_end || halt_hit[c])
            next_in_pkt[c] = 1'b0;
         if (halt_hit[c])
         begin
            next_rx_halt[c]  = 1'b1;
            next_ovr_pend[c] = 1'b1;
         end
         if (hdlc_i[c].rx_fifo_read)
         begin
            next_pkt_state[c] = ovr_pend[c] ? hfe_pkg::PS_OVERRUN
                                : hdlc_i[c].rx_read_state;
            next_ovr_pend[c]  = halt_hit[c];
         end

         if (hdlc_i[c].tx_msg_end)
            next_tx_open[c] = 1'b0;
         else if (hdlc_i[c].tx_level != 8'h00)
            next_tx_open[c] = 1'b1;
         if (underrun_hit[c])
         begin
            next_tx_open[c]  = 1'b0;
            next_tx_abort[c] = 1'b1;
            next_underrun[c] = 1'b1;
         end
      end

      if (link_i.bit_valid)
      begin
         if (!link_i.bit_value)
            next_ones_cnt = 4'h0;
         else if (ones_cnt != hfe_pkg::ABORT_ONES)
            next_ones_cnt = ones_cnt + 4'h1;
         if (link_i.bit_value && ones_cnt == hfe_pkg::ABORT_ONES - 4'h1)
         begin
            next_dl_stat[4] = 1'b1;
            next_clr_cnt    = 5'h00;
         end
         else if (clr_cnt != hfe_pkg::CLEAR_BITS)
         begin
            next_clr_cnt = clr_cnt + 5'h01;
            if (clr_cnt == hfe_pkg::CLEAR_BITS - 5'h01)
               next_dl_stat[5] = 1'b1;
         end
      end
      if (link_i.rx_buffer_full)
         next_dl_stat[3] = 1'b1;
      if (link_i.tx_buffer_drained)
         next_dl_stat[2] = 1'b1;
      if (link_i.byte_valid && (link_i.byte_value == match_one ||
                                link_i.byte_value == match_two))
         next_dl_stat[1] = 1'b1;
      if (link_i.code_change)
         next_dl_stat[0] = 1'b1;
   end

   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         es_stat    <= 6'h00;
         hd_evt     <= '0;
         cond_prev  <= {2{4'h1}};                         // idle level
         cond_edge  <= '0;
         underrun   <= 2'b00;
         tx_open    <= 2'b00;
         in_pkt     <= 2'b00;
         ovr_pend   <= 2'b00;
         pkt_state  <= '0;
         dl_stat    <= 6'h00;
         ones_cnt   <= 4'h0;
         clr_cnt    <= 5'h00;
         rx_halt_o  <= 2'b00;
         tx_abort_o <= 2'b00;
      end
      else
      begin
         es_stat    <= next_es_stat;
         hd_evt     <= next_hd_evt;
         cond_prev  <= next_cond_prev;
         cond_edge  <= next_cond_edge;
         underrun   <= next_underrun;
         tx_open    <= next_tx_open;
         in_pkt     <= next_in_pkt;
         ovr_pend   <= next_ovr_pend;
         pkt_state  <= next_pkt_state;
         dl_stat    <= next_dl_stat;
         ones_cnt   <= next_ones_cnt;
         clr_cnt    <= next_clr_cnt;
         rx_halt_o  <= next_rx_halt;
         tx_abort_o <= next_tx_abort;
      end
   end

   // ****************************************
   // register port, masks and interrupt
   // ****************************************
   always_comb
   begin
      next_es_mask   = es_mask;
      next_hd_mask   = hd_mask;
      next_dl_mask   = dl_mask;
      next_match_one = match_one;
      next_match_two = match_two;
      next_mf_mask   = mf_mask;
      if (wr_i)
      begin
         unique case (addr_i)
            hfe_pkg::ADDR_ES_MASK:   next_es_mask    = wdata_i[5:0];
            hfe_pkg::ADDR_H1_MASK:   next_hd_mask[0] = wdata_i[6:0];
            hfe_pkg::ADDR_H2_MASK:   next_hd_mask[1] = wdata_i[6:0];
            hfe_pkg::ADDR_DL_MASK:   next_dl_mask    = wdata_i[5:0];
            hfe_pkg::ADDR_MATCH_ONE: next_match_one  = wdata_i;
            hfe_pkg::ADDR_MATCH_TWO: next_match_two  = wdata_i;
            hfe_pkg::ADDR_MF_MASK:   next_mf_mask    = wdata_i;
            default:                 next_mf_mask    = mf_mask;
         endcase
      end

      next_rdata = 8'h00;
      if (rd_i)
      begin
         unique case (addr_i)
            hfe_pkg::ADDR_ES_STAT:   next_rdata = {2'b00, es_stat};
            hfe_pkg::ADDR_ES_MASK:   next_rdata = {2'b00, es_mask};
            hfe_pkg::ADDR_H1_STAT:   next_rdata = {1'b0, hd_evt[0], cond[0]};
            hfe_pkg::ADDR_H1_MASK:   next_rdata = {1'b0, hd_mask[0]};
            hfe_pkg::ADDR_H2_STAT:   next_rdata = {1'b0, hd_evt[1], cond[1]};
            hfe_pkg::ADDR_H2_MASK:   next_rdata = {1'b0, hd_mask[1]};
            hfe_pkg::ADDR_DL_STAT:   next_rdata = {2'b00, dl_stat};
            hfe_pkg::ADDR_DL_MASK:   next_rdata = {2'b00, dl_mask};
            hfe_pkg::ADDR_UO_INFO:   next_rdata = {4'h0,
               underrun[1], hdlc_i[1].rx_first_byte,
               underrun[0], hdlc_i[0].rx_first_byte};
            hfe_pkg::ADDR_H1_INFO:   next_rdata = {2'b00,
               hdlc_i[0].tx_level == 8'h00,
               hdlc_i[0].tx_level == hfe_pkg::FIFO_DEPTH,
               hdlc_i[0].rx_level == 8'h00, pkt_state[0]};
            hfe_pkg::ADDR_H2_INFO:   next_rdata = {2'b00,
               hdlc_i[1].tx_level == 8'h00,
               hdlc_i[1].tx_level == hfe_pkg::FIFO_DEPTH,
               hdlc_i[1].rx_level == 8'h00, pkt_state[1]};
            hfe_pkg::ADDR_MATCH_ONE: next_rdata = match_one;
            hfe_pkg::ADDR_MATCH_TWO: next_rdata = match_two;
            hfe_pkg::ADDR_MF_MASK:   next_rdata = mf_mask;
            default:                 next_rdata = 8'h00;
         endcase
      end

      next_irq = |(es_stat & es_mask) | |(dl_stat & dl_mask) |
                 |({hd_evt[0], cond_edge[0]} & hd_mask[0]) |
                 |({hd_evt[1], cond_edge[1]} & hd_mask[1]);
   end

   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         es_mask   <= hfe_pkg::REG_RESET[5:0];
         hd_mask   <= '0;
         dl_mask   <= hfe_pkg::REG_RESET[5:0];
         match_one <= hfe_pkg::REG_RESET;
         match_two <= hfe_pkg::REG_RESET;
         mf_mask   <= hfe_pkg::REG_RESET;
         rdata_o   <= 8'h00;
         irq_o     <= 1'b0;
      end
      else
      begin
         es_mask   <= next_es_mask;
         hd_mask   <= next_hd_mask;
         dl_mask   <= next_dl_mask;
         match_one <= next_match_one;
         match_two <= next_match_two;
         mf_mask   <= next_mf_mask;
         rdata_o   <= next_rdata;
         irq_o     <= next_irq;
      end
   end

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);

   sequence s_rx_rise;
      $rose(cond[0][2]) && hd_mask[0][2];
   endsequence

   tx_slip_set_a: assert property (store_i.tx_overflow |=>
      es_stat[5] && es_stat[3]) else $error("tx slip not latched");
   rx_slip_set_a: assert property (store_i.rx_underflow |=>
      es_stat[1] && es_stat[0]) else $error("rx slip not latched");
   msg_done_a: assert property (hdlc_i[0].tx_message_done |=>
      hd_evt[0][2]) else $error("message done lost");
   start_clear_a: assert property (stat_rd[0] &&
      !hdlc_i[0].rx_packet_start ##1 !hdlc_i[0].rx_packet_start |->
      !hd_evt[0][0]) else $error("packet start not cleared");
   masked_quiet_a: assert property ((es_mask == 6'h00 &&
      dl_mask == 6'h00 && hd_mask == '0) [*2] |-> !irq_o)
      else $error("interrupt while all masked");
   edge_irq_a: assert property (s_rx_rise ##1 !stat_rd[0] |=>
      irq_o) else $error("rising edge gave no interrupt");
   halt_end_a: assert property (rx_halt_o[0] |-> hd_evt[0][1] &&
      !in_pkt[0] && ovr_pend[0]) else $error("halt without overrun");
   overrun_state_a: assert property (ovr_pend[0] &&
      hdlc_i[0].rx_fifo_read |=> pkt_state[0] == hfe_pkg::PS_OVERRUN)
      else $error("overrun not reported");
   underrun_a: assert property (underrun_hit[1] |=>
      tx_abort_o[1] && underrun[1] ##1 !tx_abort_o[1])
      else $error("underrun abort missing");
   link_abort_a: assert property (link_i.bit_valid &&
      link_i.bit_value && ones_cnt == 4'h7 |=> dl_stat[4])
      else $error("link abort not latched");
   code_clear_a: assert property (link_i.bit_valid &&
      clr_cnt == 5'h1D && !(link_i.bit_value && ones_cnt == 4'h7)
      |=> dl_stat[5] && clr_cnt == 5'h1E)
      else $error("code clear count wrong");
   match_a: assert property (link_i.byte_valid &&
      link_i.byte_value == match_two |=> dl_stat[1])
      else $error("match not latched");
   read_zero_a: assert property (rd_i && addr_i == 8'h40 |=>
      rdata_o == 8'h00) else $error("unmapped read not zero");

endmodule

`default_nettype wire

// [tb/test_framer_hdlc_event_status_mask.sv]
// Self-checking bench for the event, status and mask block.
// Assumes the block alone, driven at its register port and event inputs.
`default_nettype none

module test_framer_hdlc_event_status_mask;
   timeunit 1ns;
   timeprecision 1ps;

   // ********************************
   // signals and rows
   // ********************************
   typedef struct packed {
      hfe_pkg::hfe_store_t ev;
      logic [7:0]          exp;
   } hfe_row_t;

   logic                     clk_i = 1'b0;
   logic                     rstn_i = 1'b0;
   logic [7:0]               addr_i = 8'h00;
   logic [7:0]               wdata_i = 8'h00;
   logic                     wr_i = 1'b0;
   logic                     rd_i = 1'b0;
   hfe_pkg::hfe_store_t      store_i = '0;
   hfe_pkg::hfe_hdlc_t [1:0] hdlc_i = '0;
   hfe_pkg::hfe_link_t       link_i = '0;
   logic [7:0]               rdata_o;
   logic                     irq_o;
   logic [1:0]               rx_halt_o;
   logic [1:0]               tx_abort_o;
   logic [3:0]               pulses;
   int                       errors = 0;
   int                       n_compared = 0;
   int                       k;
   hfe_row_t rows [4] = '{'{4'h8, 8'h28}, '{4'h4, 8'h18},
                          '{4'h2, 8'h05}, '{4'h1, 8'h03}};
   logic [7:0] zero_regs [7] = '{8'h1E, 8'h1F, 8'h21, 8'h23,
                                 8'h24, 8'h25, 8'h40};

   assign pulses = {tx_abort_o, rx_halt_o};

   always #5 clk_i = ~clk_i;

   hfe_events hfe_events_inst (
      .clk_i      (clk_i),
      .rstn_i     (rstn_i),
      .addr_i     (addr_i),
      .wdata_i    (wdata_i),
      .wr_i       (wr_i),
      .rd_i       (rd_i),
      .store_i    (store_i),
      .hdlc_i     (hdlc_i),
      .link_i     (link_i),
      .rdata_o    (rdata_o),
      .irq_o      (irq_o),
      .rx_halt_o  (rx_halt_o),
      .tx_abort_o (tx_abort_o)
   );

   // ********************************
   // tasks
   // ********************************
   task check(input logic [7:0] seen, input logic [7:0] exp,
              input string what);
      n_compared++;
      if (seen !== exp)
      begin
         errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask

   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      addr_i  <= a;
      wdata_i <= d;
      wr_i    <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask

   task rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk_i);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1;
      check(rdata_o, exp, $sformatf("register %h", a));
   endtask

   task irq_is(input logic v);
      #1;
      check({7'h00, irq_o}, {7'h00, v}, "irq");
   endtask

   // bounded wait for a one-cycle output pulse
   task wait_pulse(input int which);
      #1;
      for (k = 0; k < 4 && pulses[which] !== 1'b1; k++)
      begin
         @(posedge clk_i);
         #1;
      end
      check({7'h00, pulses[which]}, 8'h01, "output pulse");
      @(posedge clk_i);
      #1;
      check({4'h0, pulses}, 8'h00, "pulse length");
   endtask

   task send_bits(input int n, input logic v);
      repeat (n)
      begin
         @(posedge clk_i);
         link_i.bit_valid <= 1'b1;
         link_i.bit_value <= v;
      end
      @(posedge clk_i);
      link_i.bit_valid <= 1'b0;
   endtask

   task final_report;
      $display("compared %0d, mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   initial
   begin
      #500000;
      errors++;
      final_report;
   end

   // ********************************
   // main sequence
   // ********************************
   initial
   begin
      hdlc_i[0].rx_high_watermark_value = 8'h80;
      hdlc_i[1].rx_high_watermark_value = 8'h80;
      repeat (3) @(posedge clk_i);
      rstn_i <= 1'b1;
      foreach (zero_regs[i])
         rd(zero_regs[i], 8'h00);
      $display("test reset done");
      foreach (rows[i])
      begin
         @(posedge clk_i);
         store_i <= rows[i].ev;
         @(posedge clk_i);
         store_i <= '0;
         rd(8'h1E, rows[i].exp);
         rd(8'h1E, 8'h00);
      end
      $display("test store events done");
      wr(8'h1F, 8'hFF);
      rd(8'h1F, 8'h3F);
      wr(8'h23, 8'hFF);
      rd(8'h23, 8'h7F);
      wr(8'h23, 8'h00);
      wr(8'h1F, 8'h20);
      @(posedge clk_i);
      store_i <= 4'h1;
      @(posedge clk_i);
      store_i <= 4'h8;
      @(posedge clk_i);
      store_i <= '0;
      irq_is(1'b0);
      @(posedge clk_i);
      irq_is(1'b1);
      rd(8'h1E, 8'h2B);
      repeat (2) @(posedge clk_i);
      irq_is(1'b0);
      $display("test store mask done");
      wr(8'h21, 8'h04);
      rd(8'h20, 8'h01);
      @(posedge clk_i);
      hdlc_i[0].rx_level <= 8'h03;
      repeat (3) @(posedge clk_i);
      irq_is(1'b1);
      @(posedge clk_i);
      hdlc_i[0].rx_high_watermark_value <= 8'h02;
      hdlc_i[0].tx_low_watermark_value <= 8'h01;
      rd(8'h20, 8'h0F);
      repeat (2) @(posedge clk_i);
      irq_is(1'b0);
      $display("test fifo edge done");
      @(posedge clk_i);
      hdlc_i[0].rx_packet_start <= 1'b1;
      hdlc_i[0].rx_high_watermark_value <= 8'h80;
      hdlc_i[0].rx_level <= 8'h80;
      @(posedge clk_i);
      hdlc_i[0].rx_packet_start <= 1'b0;
      hdlc_i[0].rx_byte_write <= 1'b1;
      @(posedge clk_i);
      hdlc_i[0].rx_byte_write <= 1'b0;
      wait_pulse(0);
      @(posedge clk_i);
      hdlc_i[0].rx_fifo_read <= 1'b1;
      hdlc_i[0].rx_read_state <= hfe_pkg::PS_GOOD;
      @(posedge clk_i);
      hdlc_i[0].rx_fifo_read <= 1'b0;
      rd(8'h2E, 8'h24);
      rd(8'h20, 8'h37);
      for (int c = 0; c < 4; c++)
      begin
         @(posedge clk_i);
         hdlc_i[0].rx_fifo_read <= 1'b1;
         hdlc_i[0].rx_read_state <= c[2:0];
         @(posedge clk_i);
         hdlc_i[0].rx_fifo_read <= 1'b0;
         rd(8'h2E, 8'h20 | c[7:0]);
      end
      $display("test overrun done");
      @(posedge clk_i);
      hdlc_i[1].tx_message_done <= 1'b1;
      @(posedge clk_i);
      hdlc_i[1].tx_message_done <= 1'b0;
      rd(8'h22, 8'h41);
      rd(8'h2F, 8'h28);
      @(posedge clk_i);
      hdlc_i[1].tx_level <= 8'h80;
      rd(8'h2F, 8'h18);
      rd(8'h22, 8'h00);
      @(posedge clk_i);
      hdlc_i[1].tx_level <= 8'h00;
      wait_pulse(3);
      rd(8'h2D, 8'h08);
      rd(8'h2D, 8'h00);
      $display("test underrun done");
      send_bits(8, 1'b1);
      rd(8'h24, 8'h10);
      send_bits(29, 1'b0);
      rd(8'h24, 8'h00);
      send_bits(1, 1'b0);
      rd(8'h24, 8'h20);
      wr(8'h31, 8'h5A);
      wr(8'h30, 8'hA5);
      wr(8'h32, 8'hC3);
      rd(8'h32, 8'hC3);
      wr(8'h25, 8'hFF);
      rd(8'h25, 8'h3F);
      wr(8'h25, 8'h02);
      @(posedge clk_i);
      link_i.rx_buffer_full <= 1'b1;
      link_i.tx_buffer_drained <= 1'b1;
      link_i.code_change <= 1'b1;
      link_i.byte_valid <= 1'b1;
      link_i.byte_value <= 8'h5A;
      @(posedge clk_i);
      link_i <= '0;
      rd(8'h24, 8'h0F);
      @(posedge clk_i);
      link_i.byte_valid <= 1'b1;
      link_i.byte_value <= 8'hA5;
      @(posedge clk_i);
      link_i <= '0;
      @(posedge clk_i);
      irq_is(1'b1);
      rd(8'h24, 8'h02);
      repeat (2) @(posedge clk_i);
      irq_is(1'b0);
      $display("test data link done");
      @(posedge clk_i);
      rstn_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      rstn_i <= 1'b1;
      irq_is(1'b0);
      rd(8'h1F, 8'h00);
      rd(8'h21, 8'h00);
      rd(8'h25, 8'h00);
      $display("test second reset done");
      final_report;
   end
endmodule

`default_nettype wire
